// >>> design/pbc_defines.vh
// Constants for the panel and bootstrap control block.
// Assumes a 10 MHz system clock and an Avalon-MM master on the register side.
// Function
// R1 - Bootstrap writes a jump-to-zero word into location zero.
// R2 - Bootstrap stores control word at 00040: count 1023, address 00041.
// R3 - Bootstrap pulses channel zero external function with output word 0100.
// R4 - Bootstrap arms channel zero buffered input with interrupt on termination.
// R5 - After setup, run starts execution at zero, spinning on the self-jump.
// R6 - Buffer termination interrupts to 00060 or 00120 by program type.
// R7 - Bootstrap runs only after load press-and-release, then a run request.
// R8 - Global clear returns all machine status to cleared state.
// R9 - In run, program counter advances by one after non-jump, non-skip instructions.
// R10 - Clear-arithmetic-control resets all four sequencer flip-flops to zero.
// R11 - Sequencer codes: 0000 single, 1000 scale A, 0010 shift, 1010 scale AQ.
// R12 - Reverse bits uses 0011, 0111, 1111; multiply uses 1011.
// R13 - Division steps 0100,1100,0110,1110,0101,1101,0001; 0001 also negates A.
// R14 - Six-bit shift count shown always; per-bit set, whole clear.
// R15 - Q, H, Z, I, D are 24 bits with per-bit set, clear, display.
// R16 - Memory address register is 14 bits with per-bit set and clear.
// R17 - Channel data register is 24 bits, or 30 when wide channels fitted.
// R18 - Adder source flagged: transient, accumulator, or accumulator halved.
// R19 - Flags show forced low carry and enabled carry circuits separately.
// R20 - Multiply/divide use a Q extension bit; divide flags zero remainder.
// R21 - Arithmetic control holds four bits, one lit, zero unlit.
// R22 - Whole-register clear beats per-bit set in the same cycle.
`ifndef PBC_DEFINES_VH
`define PBC_DEFINES_VH

// ============================================================
// Register byte offsets
`define PBC_OFS_CTRL 6'h00
`define PBC_OFS_NCNT 6'h04
`define PBC_OFS_QREG 6'h08
`define PBC_OFS_HREG 6'h0c
`define PBC_OFS_ZREG 6'h10
`define PBC_OFS_IREG 6'h14
`define PBC_OFS_SREG 6'h18
`define PBC_OFS_DREG 6'h1c
`define PBC_OFS_XREG 6'h20
`define PBC_OFS_ARC 6'h24
`define PBC_OFS_PCNT 6'h28
`define PBC_OFS_FLAGS 6'h2c

// ============================================================
// Control word fields
`define PBC_CTL_MCLR 0
`define PBC_CTL_LOAD 1
`define PBC_CTL_RUN 2
`define PBC_CTL_ACLR 3
`define PBC_CTL_BTYPE 4
`define PBC_CTL_STOP 5
`define PBC_CTL_WIDE 6
`define PBC_REG_CLR 31

// ============================================================
// Bootstrap constants
`define PBC_JMP_OP 10'h2a8
`define PBC_BCW_LOC 14'h0020
`define PBC_BCW_CNT 10'h3ff
`define PBC_BCW_ADR 14'h0021
`define PBC_EF_WORD 24'h000040
`define PBC_VEC_A 14'h0030
`define PBC_VEC_B 14'h0050

// ============================================================
// Arithmetic operation codes written to the sequencer
`define PBC_OP_SINGLE 3'h0
`define PBC_OP_SCALEA 3'h1
`define PBC_OP_SHIFT 3'h2
`define PBC_OP_SCALEAQ 3'h3
`define PBC_OP_REVERSE 3'h4
`define PBC_OP_MULT 3'h5
`define PBC_OP_DIV 3'h6
`define PBC_OP_NEG 3'h7

`endif

// >>> design/pbc_core.v
// Maintenance panel register control, arithmetic control sequencer and bootstrap loader.
// Assumes an Avalon-MM master and a channel zero peripheral on asynchronous pins.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defines.vh"

module pbc_core (
	input wire i_sys_clk,
	input wire i_rst_b,
	input wire [5:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	output reg [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	input wire i_instr_done,
	input wire i_instr_jump,
	input wire [13:0] i_jump_addr,
	input wire i_ch0_buf_term,
	output reg o_mem_wr,
	output reg [13:0] o_mem_addr,
	output reg [23:0] o_mem_wdata,
	output reg o_ch0_ext_func,
	output reg [23:0] o_ch0_out,
	output reg o_ch0_buf_in_en,
	output reg o_ch0_monitor,
	output reg o_run,
	output reg [13:0] o_p_count,
	output reg [3:0] o_arith_ctl
);

	// ============================================================
	// Boot states
	localparam BS_IDLE = 3'h0;
	localparam BS_JMP = 3'h1;
	localparam BS_BCW = 3'h2;
	localparam BS_EF = 3'h3;
	localparam BS_ARM = 3'h4;
	localparam BS_WAITRUN = 3'h5;
	localparam BS_SPIN = 3'h6;

	// ============================================================
	// Bus slave: one wait cycle on every access
	// Read data is registered; the wait cycle gives it time to load
	reg ack_ff;
	wire req = i_avs_read | i_avs_write;
	wire wr_go = i_avs_write & ack_ff;
	wire [31:0] wd = i_avs_writedata;
	assign o_avs_waitrequest = req & ~ack_ff;

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end

	// Control strobes act only on the accepting edge
	wire ctl_wr = wr_go & (i_avs_address == `PBC_OFS_CTRL);
	// Master clear resets machine status but not the bus handshake
	wire mclr = ctl_wr & wd[`PBC_CTL_MCLR];

	// ============================================================
	// Panel registers: N, Q, H, Z, I, S, D, X
	// One 30-bit slot per register, so each slice has a single driver
	wire [239:0] pr_flat;
	reg wide_ff;
	wire [29:0] xmask = wide_ff ? 30'h3fffffff : 30'h00ffffff;

	genvar k;
	generate
		for (k = 0; k < 8; k = k + 1) begin : g_preg
			localparam [31:0] OFS_FULL = `PBC_OFS_NCNT + k * 4;
			wire [5:0] ofs = OFS_FULL[5:0];
			// Narrow registers drop their unused upper bits
			wire [29:0] msk = (k == 0) ? 30'h0000003f :
				(k == 5) ? 30'h00003fff :
				(k == 7) ? xmask : 30'h00ffffff;
			wire hit = wr_go & (i_avs_address == ofs);
			reg [29:0] val_ff;

			always @(posedge i_sys_clk) begin
				if (!i_rst_b || mclr) begin
					val_ff <= 30'h0; // R8
				end else if (hit && wd[`PBC_REG_CLR]) begin
					val_ff <= 30'h0; // R22
				end else if (hit) begin
					val_ff <= val_ff | (wd[29:0] & msk); // R14 R15 R16 R17
				end
			end

			assign pr_flat[k * 30 +: 30] = val_ff;
		end
	endgenerate

	// ============================================================
	// Arithmetic control sequencer
	reg [3:0] nxt_arc;
	reg [2:0] op_ff;
	reg [2:0] step_ff;
	reg busy_ff;
	reg qext_ff;
	reg zrem_ff;
	// A new op is refused while one is still stepping
	wire arc_wr = wr_go & (i_avs_address == `PBC_OFS_ARC);
	wire aclr = ctl_wr & wd[`PBC_CTL_ACLR];

	// Step tables; last entry returns to the single-cycle code
	always @* begin
		nxt_arc = 4'h0;
		case (op_ff)
			`PBC_OP_SCALEA: nxt_arc = (step_ff == 3'h0) ? 4'h8 : 4'h0; // R11
			`PBC_OP_SHIFT: nxt_arc = (step_ff == 3'h0) ? 4'h2 : 4'h0; // R11
			`PBC_OP_SCALEAQ: nxt_arc = (step_ff == 3'h0) ? 4'ha : 4'h0; // R11
			`PBC_OP_REVERSE: begin
				case (step_ff) // R12
					3'h0: nxt_arc = 4'h3;
					3'h1: nxt_arc = 4'h7;
					3'h2: nxt_arc = 4'hf;
					default: nxt_arc = 4'h0;
				endcase
			end
			`PBC_OP_MULT: nxt_arc = (step_ff == 3'h0) ? 4'hb : 4'h0; // R12
			`PBC_OP_DIV: begin
				case (step_ff) // R13
					3'h0: nxt_arc = 4'h4;
					3'h1: nxt_arc = 4'hc;
					3'h2: nxt_arc = 4'h6;
					3'h3: nxt_arc = 4'he;
					3'h4: nxt_arc = 4'h5;
					3'h5: nxt_arc = 4'hd;
					3'h6: nxt_arc = 4'h1;
					default: nxt_arc = 4'h0;
				endcase
			end
			`PBC_OP_NEG: nxt_arc = (step_ff == 3'h0) ? 4'h1 : 4'h0; // R13
			default: nxt_arc = 4'h0; // R11
		endcase
	end

	wire in_div = (op_ff == `PBC_OP_DIV) & busy_ff;
	wire in_mul = (op_ff == `PBC_OP_MULT) & busy_ff;

	always @(posedge i_sys_clk) begin
		if (!i_rst_b || mclr || aclr) begin
			o_arith_ctl <= 4'h0; // R10 R21
			op_ff <= `PBC_OP_SINGLE;
			step_ff <= 3'h0;
			busy_ff <= 1'b0;
			qext_ff <= 1'b0;
			zrem_ff <= 1'b0;
		end else if (arc_wr && !busy_ff) begin
			op_ff <= wd[2:0];
			step_ff <= 3'h0;
			busy_ff <= 1'b1;
			zrem_ff <= 1'b0;
		end else if (busy_ff) begin
			o_arith_ctl <= nxt_arc;
			step_ff <= step_ff + 3'h1;
			// Step 0 never ends an op, even for the single-cycle code
			if (nxt_arc == 4'h0 && step_ff != 3'h0) begin
				busy_ff <= 1'b0;
			end
			// Extension bit is set while multiplying or dividing and holds until the next op steps or a clear
			qext_ff <= in_div | in_mul; // R20
			// Q holds the partial remainder during division
			if (in_div && pr_flat[53:30] == 24'h0) begin
				zrem_ff <= 1'b1; // R20
			end
		end
	end

	// Adder path indicators decoded from the sequencer state
	// Divide and multiply gate D; idle and negate gate A
	wire sel_d = in_div | in_mul; // R18
	wire sel_a = ~busy_ff | (op_ff == `PBC_OP_NEG); // R18
	wire halved_accumulator_to_adder_flag = busy_ff &
		((op_ff == `PBC_OP_SCALEA) | (op_ff == `PBC_OP_SCALEAQ)); // R18
	wire carry_forced = busy_ff & ((op_ff == `PBC_OP_NEG) | in_div); // R19
	wire carry_enable = in_div | in_mul | carry_forced; // R19
	wire quotient_extension_bit = qext_ff;
	wire zero_remainder_flag = zrem_ff;

	// ============================================================
	// Channel zero termination pin synchroniser
	// Only the second stage and its delayed copy feed logic; the first may be metastable
	reg term_s1_ff;
	reg term_s2_ff;
	reg term_d_ff;
	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			term_s1_ff <= 1'b0;
			term_s2_ff <= 1'b0;
			term_d_ff <= 1'b0;
		end else begin
			term_s1_ff <= i_ch0_buf_term;
			term_s2_ff <= term_s1_ff;
			term_d_ff <= term_s2_ff;
		end
	end
	wire term_rise = term_s2_ff & ~term_d_ff;
	// A termination that lands before run is pressed must not be lost
	reg term_pend_ff;
	wire term_hit = term_rise | term_pend_ff;

	// ============================================================
	// Panel push-buttons
	reg load_hold_ff;
	reg load_armed_ff;
	reg btype_ff;
	wire load_bit = wd[`PBC_CTL_LOAD];
	wire run_req = ctl_wr & wd[`PBC_CTL_RUN];
	wire stop_req = ctl_wr & wd[`PBC_CTL_STOP];
	reg [2:0] bs_ff;

	always @(posedge i_sys_clk) begin
		if (!i_rst_b || mclr) begin
			load_hold_ff <= 1'b0;
			load_armed_ff <= 1'b0;
			btype_ff <= 1'b0;
			wide_ff <= 1'b0;
		end else begin
			// Press is a write with the load bit set, release one with it clear
			// Every control write rewrites type and width; software keeps them
			if (ctl_wr) begin
				load_hold_ff <= load_bit;
				btype_ff <= wd[`PBC_CTL_BTYPE];
				wide_ff <= wd[`PBC_CTL_WIDE];
			end
			// Latch only on release so a held button cannot retrigger
			if (ctl_wr && load_hold_ff && !load_bit) begin
				load_armed_ff <= 1'b1; // R7
			end else if (bs_ff != BS_IDLE) begin
				load_armed_ff <= 1'b0;
			end
		end
	end

	// ============================================================
	// Bootstrap sequence and program counter
	// Boot steps run one per clock, then wait for the second run request
	always @(posedge i_sys_clk) begin
		if (!i_rst_b || mclr) begin
			bs_ff <= BS_IDLE; // R8
			o_mem_wr <= 1'b0;
			o_mem_addr <= 14'h0;
			o_mem_wdata <= 24'h0;
			o_ch0_ext_func <= 1'b0;
			o_ch0_out <= 24'h0;
			o_ch0_buf_in_en <= 1'b0;
			o_ch0_monitor <= 1'b0;
			o_run <= 1'b0;
			o_p_count <= 14'h0;
			term_pend_ff <= 1'b0;
		end else begin
			o_mem_wr <= 1'b0;
			o_ch0_ext_func <= 1'b0;
			if (term_rise && o_ch0_monitor && bs_ff != BS_SPIN) begin
				term_pend_ff <= 1'b1; // R6
			end
			case (bs_ff)
				BS_IDLE: begin
					if (run_req && load_armed_ff && !o_run) begin
						bs_ff <= BS_JMP; // R7
					end else if (run_req) begin
						o_run <= 1'b1;
					end else if (stop_req) begin
						o_run <= 1'b0;
					end
				end
				BS_JMP: begin
					o_mem_wr <= 1'b1;
					o_mem_addr <= 14'h0;
					o_mem_wdata <= {`PBC_JMP_OP, 14'h0}; // R1
					bs_ff <= BS_BCW;
				end
				BS_BCW: begin
					o_mem_wr <= 1'b1;
					o_mem_addr <= `PBC_BCW_LOC;
					o_mem_wdata <= {`PBC_BCW_CNT, `PBC_BCW_ADR}; // R2
					bs_ff <= BS_EF;
				end
				BS_EF: begin
					// Output word stays on the lines after the pulse
					o_ch0_ext_func <= 1'b1;
					o_ch0_out <= `PBC_EF_WORD; // R3
					bs_ff <= BS_ARM;
				end
				BS_ARM: begin
					o_ch0_buf_in_en <= 1'b1; // R4
					o_ch0_monitor <= 1'b1; // R4
					bs_ff <= BS_WAITRUN;
				end
				BS_WAITRUN: begin
					if (run_req) begin
						o_run <= 1'b1; // R5
						o_p_count <= 14'h0; // R5
						bs_ff <= BS_SPIN;
					end
				end
				BS_SPIN: begin
					// Self-jump holds P at zero until the channel interrupt
					if (term_hit && o_ch0_monitor) begin
						term_pend_ff <= 1'b0;
						o_p_count <= btype_ff ? `PBC_VEC_B : `PBC_VEC_A; // R6
						o_ch0_buf_in_en <= 1'b0;
						o_ch0_monitor <= 1'b0;
						bs_ff <= BS_IDLE;
					end else if (stop_req) begin
						o_run <= 1'b0;
					end else if (run_req) begin
						o_run <= 1'b1;
					end
				end
				default: bs_ff <= BS_IDLE;
			endcase
			// Jumps and skips supply their own target
			if (o_run && bs_ff == BS_IDLE && i_instr_done) begin
				if (i_instr_jump) begin
					o_p_count <= i_jump_addr;
				end else begin
					o_p_count <= o_p_count + 14'h1; // R9
				end
			end
			if (bs_ff == BS_IDLE && !o_run && ctl_wr && !run_req &&
				i_avs_address == `PBC_OFS_CTRL) begin
				o_p_count <= o_p_count;
			end
			// P may only be set from the panel while stopped
			if (wr_go && i_avs_address == `PBC_OFS_PCNT && !o_run) begin
				o_p_count <= wd[13:0];
			end
		end
	end

	// ============================================================
	// Read mux
	// Captured at the request edge; readdata then stands until the next read
	// X shows only the fitted width after a width change
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h0;
		case (i_avs_address)
			`PBC_OFS_CTRL: rd_val = {21'h0, o_ch0_monitor, o_ch0_buf_in_en, bs_ff,
				load_armed_ff, wide_ff, btype_ff, o_run, busy_ff};
			`PBC_OFS_NCNT: rd_val = {2'h0, pr_flat[29:0]};
			`PBC_OFS_QREG: rd_val = {2'h0, pr_flat[59:30]};
			`PBC_OFS_HREG: rd_val = {2'h0, pr_flat[89:60]};
			`PBC_OFS_ZREG: rd_val = {2'h0, pr_flat[119:90]};
			`PBC_OFS_IREG: rd_val = {2'h0, pr_flat[149:120]};
			`PBC_OFS_SREG: rd_val = {2'h0, pr_flat[179:150]};
			`PBC_OFS_DREG: rd_val = {2'h0, pr_flat[209:180]};
			`PBC_OFS_XREG: rd_val = {2'h0, pr_flat[239:210] & xmask};
			`PBC_OFS_ARC: rd_val = {28'h0, o_arith_ctl}; // R21
			`PBC_OFS_PCNT: rd_val = {18'h0, o_p_count};
			`PBC_OFS_FLAGS: rd_val = {25'h0, zero_remainder_flag, quotient_extension_bit,
				carry_enable, carry_forced, halved_accumulator_to_adder_flag, sel_a, sel_d};
			default: rd_val = 32'h0;
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_avs_readdata <= 32'h0;
		end else if (i_avs_read && !ack_ff) begin
			o_avs_readdata <= rd_val;
		end
	end

endmodule
`default_nettype wire

// >>> verification/pbc_core_asserts.sv
// Checker bound to the pbc_core ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pbc_core_asserts (
	input wire i_sys_clk,
	input wire i_rst_b,
	input wire [5:0] i_avs_address,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire o_avs_waitrequest,
	input wire i_instr_done,
	input wire i_instr_jump,
	input wire o_mem_wr,
	input wire [13:0] o_mem_addr,
	input wire [23:0] o_mem_wdata,
	input wire o_ch0_ext_func,
	input wire [23:0] o_ch0_out,
	input wire o_ch0_buf_in_en,
	input wire o_ch0_monitor,
	input wire o_run,
	input wire [13:0] o_p_count,
	input wire [3:0] o_arith_ctl
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	// =====
	// Control word accepted on this edge
	wire ctl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00;
	property p_jump_word;
		o_mem_wr && o_mem_addr == 14'h0000 |-> o_mem_wdata == 24'haa0000;
	endproperty
	a_jump_word: assert property (p_jump_word) else $error("bad self-jump word");
	property p_bcw;
		o_mem_wr && o_mem_addr == 14'h0020 |-> o_mem_wdata == 24'hffc021;
	endproperty
	a_bcw: assert property (p_bcw) else $error("bad buffer control word");
	property p_ext_func;
		o_ch0_ext_func |-> o_ch0_out == 24'h000040 ##1 !o_ch0_ext_func;
	endproperty
	a_ext_func: assert property (p_ext_func) else $error("bad external function");
	property p_arm;
		$rose(o_ch0_buf_in_en) |-> o_ch0_monitor;
	endproperty
	a_arm: assert property (p_arm) else $error("buffer armed without monitor");
	property p_mclr;
		ctl_wr && i_avs_writedata[0] |=> !o_run && o_p_count == 14'h0 && o_arith_ctl == 4'h0;
	endproperty
	a_mclr: assert property (p_mclr) else $error("master clear left state");
	property p_p_step;
		o_run && i_instr_done && !i_instr_jump |=> o_p_count == $past(o_p_count) + 14'h1;
	endproperty
	a_p_step: assert property (p_p_step) else $error("P did not step by one");
	property p_aclr;
		ctl_wr && i_avs_writedata[3] |=> o_arith_ctl == 4'h0;
	endproperty
	a_aclr: assert property (p_aclr) else $error("sequencer not cleared");
	property p_codes;
		o_arith_ctl != 4'b1001;
	endproperty
	a_codes: assert property (p_codes) else $error("unused sequencer code");
endmodule
bind pbc_core pbc_core_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
	.i_avs_address(i_avs_address), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_instr_done(i_instr_done), .i_instr_jump(i_instr_jump), .o_mem_wr(o_mem_wr),
	.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_ch0_ext_func(o_ch0_ext_func),
	.o_ch0_out(o_ch0_out), .o_ch0_buf_in_en(o_ch0_buf_in_en), .o_ch0_monitor(o_ch0_monitor),
	.o_run(o_run), .o_p_count(o_p_count), .o_arith_ctl(o_arith_ctl));
`default_nettype wire

// >>> verification/pbc_ch0_model.sv
// Channel zero input device: ends its buffer some time after being armed.
// Assumes arming is an external function followed by buffer enable.
`timescale 1ns/1ps
`default_nettype none
module pbc_ch0_model (
	input wire logic i_ch0_ext_func,
	input wire logic i_buf_in_en,
	output logic o_buf_term
);
	int n_fill = 0;
	initial begin
		o_buf_term = 1'b0;
		forever begin
			@(posedge i_ch0_ext_func);
			@(posedge i_buf_in_en);
			// First fill quick, later ones slow; pin is not tied to the clock
			#(n_fill == 0 ? 1330 : 5370);
			n_fill++;
			o_buf_term = 1'b1;
			@(negedge i_buf_in_en);
			o_buf_term = 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> verification/pbc_core_tb.sv
// Bench for pbc_core: panel registers, sequencer, run and bootstrap.
// Assumes pbc_ch0_model on channel zero and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module pbc_core_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] adr = 6'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic done = 1'b0;
	logic jmp = 1'b0;
	logic [13:0] jadr = 14'h0;
	wire [31:0] rdat;
	wire wait_r, mem_wr, ef, bufen, mon, run, term;
	wire [13:0] maddr, pc;
	wire [23:0] mdat, ch_out;
	wire [3:0] actl;
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 32'h539c86d9;
	logic [31:0] rd_q[$];
	logic [37:0] mw_q[$];
	logic [15:0] seen;
	logic [31:0] v, u;
	logic [13:0] p;
	logic [5:0] ofs[8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20};
	logic [31:0] msk[8] = '{32'h3f, 32'hffffff, 32'hffffff, 32'hffffff, 32'hffffff,
		32'h3fff, 32'hffffff, 32'hffffff};
	logic [15:0] need[8] = '{16'h0001, 16'h0101, 16'h0005, 16'h0401, 16'h8089,
		16'h0801, 16'h7073, 16'h0003};
	always #50 clk = ~clk;
	pbc_core dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wait_r), .i_instr_done(done), .i_instr_jump(jmp),
		.i_jump_addr(jadr), .i_ch0_buf_term(term), .o_mem_wr(mem_wr), .o_mem_addr(maddr),
		.o_mem_wdata(mdat), .o_ch0_ext_func(ef), .o_ch0_out(ch_out), .o_ch0_buf_in_en(bufen),
		.o_ch0_monitor(mon), .o_run(run), .o_p_count(pc), .o_arith_ctl(actl));
	pbc_ch0_model ch0_u (.i_ch0_ext_func(ef), .i_buf_in_en(bufen), .o_buf_term(term));
	// =====
	// Shared tasks
	task automatic check(string name, logic [37:0] got, logic [37:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatched %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
		wr <= w;
		rd <= !w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (wait_r !== 1'b0);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdx(logic [5:0] a, logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// Unexpected reads or memory writes meet an all-ones note
	always @(posedge clk) begin
		if (rd && !wait_r)
			check("readdata", rdat, rd_q.size() ? rd_q.pop_front() : '1);
		if (mem_wr)
			check("mem write", {maddr, mdat}, mw_q.size() ? mw_q.pop_front() : '1);
	end
	initial begin
		#2_000_000;
		n_errors++;
		tally_and_finish();
	end
	// =====
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 11; i++) rdx(6'(4 * i), 32'h0);
		$display("reset test done");
		foreach (ofs[i]) begin
			v = $random(seed);
			u = $random(seed);
			bus(1'b1, ofs[i], v & 32'h7fffffff);
			bus(1'b1, ofs[i], u & 32'h7fffffff);
			rdx(ofs[i], (v | u) & msk[i]);
			bus(1'b1, ofs[i], 32'h80000000 | u);
			rdx(ofs[i], 32'h0);
		end
		bus(1'b1, 6'h00, 32'h40);
		bus(1'b1, 6'h20, 32'h7fffffff);
		rdx(6'h20, 32'h3fffffff);
		$display("panel test done");
		for (int op = 0; op < 8; op++) begin
			seen = 16'h0;
			bus(1'b1, 6'h24, op);
			repeat (40) begin
				seen[actl] = 1'b1;
				@(posedge clk);
			end
			check("sequencer codes", seen & need[op], need[op]);
		end
		bus(1'b1, 6'h24, 32'h6);
		rdx(6'h2c, 32'h79);
		bus(1'b1, 6'h00, 32'h8);
		check("cleared sequencer", actl, 4'h0);
		$display("sequencer test done");
		bus(1'b1, 6'h28, 32'd100);
		bus(1'b1, 6'h00, 32'h4);
		p = 14'd100;
		repeat (12) begin
			v = $random(seed);
			done <= 1'b1;
			jmp <= v[20];
			jadr <= v[13:0];
			p = v[20] ? v[13:0] : p + 14'h1;
			@(posedge clk);
			done <= 1'b0;
			@(posedge clk);
		end
		bus(1'b1, 6'h28, 32'h5);
		bus(1'b1, 6'h00, 32'h20);
		rdx(6'h28, p);
		$display("run test done");
		for (int b = 0; b < 2; b++) begin
			bus(1'b1, 6'h00, 32'h1);
			rdx(6'h20, 32'h0);
			bus(1'b1, 6'h00, 32'h2 | b << 4);
			bus(1'b1, 6'h00, b << 4);
			mw_q.push_back({14'h0000, 24'haa0000});
			mw_q.push_back({14'h0020, 24'hffc021});
			bus(1'b1, 6'h00, 32'h4 | b << 4);
			for (int k = 0; k < 50 && bufen !== 1'b1; k++) @(posedge clk);
			check("writes left", mw_q.size(), 0);
			check("ch0 out", ch_out, 24'h000040);
			check("monitor", {bufen, mon}, 2'b11);
			// Second round lets the buffer end before run is pressed
			if (b) repeat (70) @(posedge clk);
			bus(1'b1, 6'h00, 32'h4 | b << 4);
			check("start", {run, pc}, {1'b1, 14'h0});
			for (int k = 0; k < 200 && bufen !== 1'b0; k++) @(posedge clk);
			@(posedge clk);
			check("vector", {bufen, pc}, {1'b0, b ? 14'h0050 : 14'h0030});
		end
		$display("bootstrap test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
